// *** core/pta_channel.v ***
// time accumulator channel: measures an input, sums high/low/period time, raises interrupt
// =====================================================================
// Summary of operation
// - a 32-bit running sum holds total high time, low time or period per the selected mode.
// - in period modes each period starts and ends on the configured rising or falling edge.
// - when the programmed count of measurements is reached the channel raises its interrupt.
// - the measurement count lies between 1 and 255 and the host must program it so.
// - mode 00 high time, 01 low time, 10 period from rising, 11 period from falling.
// - service request 00 is none and reset value, 11 initializes, 01 and 10 are unused.
// - priority 00 disables the channel, 01 low, 10 medium and 11 high priority.
// - the interrupt enable bit forwards the interrupt when 1 and blocks it when 0.
// - the interrupt status bit reads 1 while the interrupt is asserted and 0 otherwise.
// - the function select field must hold the accumulator's function number to run it.
// - parameter words are decoded in a page selected by unit code 41 or 44 and channel number.
`timescale 1ns/10ps
`include "pta_map.vh"
module tac_channel #(
   parameter [7:0] UNIT_CODE = `TAC_UNIT_FIRST,
   parameter [3:0] CHAN_NUM  = 4'h0
) (
   input  wire        clk,
   input  wire        resetn,
   input  wire        pin_in,
   input  wire [15:0] time_base,
   input  wire [3:0]  func_sel,
   input  wire [1:0]  host_seq,
   input  wire [1:0]  host_srv,
   input  wire [1:0]  chan_pri,
   input  wire        int_en,
   input  wire        int_clr,
   input  wire [7:0]  max_count,
   input  wire [7:0]  rd_unit,
   input  wire [3:0]  rd_chan,
   input  wire [3:0]  rd_word,
   output reg  [15:0] rd_data,
   output reg         rd_hit,
   output reg         int_status,
   output reg         int_req
);

   // =====================================================================
   // declarations
   reg         sync1_q;
   reg         sync2_q;
   reg         pin_q;
   reg  [31:0] sum_q;
   reg  [31:0] sum_d;
   reg  [7:0]  count_q;
   reg  [7:0]  count_d;
   reg  [15:0] last_time_q;
   reg  [15:0] last_time_d;
   reg         armed_q;
   reg         armed_d;
   reg         active_q;
   reg         active_d;
   reg  [31:0] result_q;
   reg  [31:0] result_d;
   reg         int_status_d;
   reg         int_req_d;
   reg  [15:0] rd_data_d;
   reg         start_edge;
   reg         end_edge;
   reg         is_period;
   wire        rise;
   wire        fall;
   wire        init_cmd;
   wire        run;
   wire        done;
   wire        page_ok;
   wire [15:0] delta;
   wire [31:0] sum_next;
   wire [7:0]  limit;
   wire [7:0]  count_next;

   // =====================================================================
   // input synchroniser; the pin is asynchronous, so two flops settle it before
   // any logic looks at it; the third flop only remembers the previous level
   always @(posedge clk) begin
      if (!resetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         pin_q   <= 1'b0;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         pin_q   <= sync2_q;
      end
   end

   assign rise = sync2_q & ~pin_q;
   assign fall = ~sync2_q & pin_q;

   // =====================================================================
   // mode decode
   always @* begin
      start_edge = 1'b0;
      end_edge   = 1'b0;
      is_period  = 1'b0;
      case (host_seq)
         `TAC_MODE_HIGH: begin
            start_edge = rise;
            end_edge   = fall;
         end
         `TAC_MODE_LOW: begin
            start_edge = fall;
            end_edge   = rise;
         end
         `TAC_MODE_PER_RISE: begin
            start_edge = rise;
            end_edge   = rise;
            is_period  = 1'b1;
         end
         default: begin
            start_edge = fall;
            end_edge   = fall;
            is_period  = 1'b1;
         end
      endcase
   end

   // =====================================================================
   // gating and completion
   assign init_cmd   = (host_srv == `TAC_HSR_INIT);
   assign run        = active_q && (chan_pri != `TAC_PRI_OFF) && (func_sel == `TAC_FUNC_NUM);
   assign delta      = time_base - last_time_q;
   assign sum_next   = sum_q + {16'h0000, delta};
   // a zero count is out of range; treating it as one makes the channel finish after every measurement
   assign limit      = (max_count == 8'h00) ? `TAC_COUNT_MIN : max_count;
   assign count_next = count_q + 8'h01;
   // initialization wins over a completing edge in the same cycle, so a re-init
   // never raises a stale interrupt; one already pending stays set until int_clr
   assign done       = !init_cmd && run && armed_q && end_edge && (count_next >= limit);

   // =====================================================================
   // accumulation, next state
   always @* begin
      sum_d       = sum_q;
      count_d     = count_q;
      last_time_d = last_time_q;
      armed_d     = armed_q;
      active_d    = active_q;
      if (init_cmd) begin
         active_d = 1'b1;
         armed_d  = 1'b0;
         sum_d    = 32'h00000000;
         count_d  = 8'h00;
      end else if (run) begin
         if (armed_q && end_edge) begin
            if (done) begin
               sum_d   = 32'h00000000;
               count_d = 8'h00;
            end else begin
               sum_d   = sum_next;
               count_d = count_next;
            end
            // period modes re-arm at once: the end edge of one period starts the next
            armed_d     = is_period;
            last_time_d = time_base;
         end else if (start_edge) begin
            armed_d     = 1'b1;
            last_time_d = time_base;
         end
      end
   end

   // =====================================================================
   // accumulation registers
   always @(posedge clk) begin
      if (!resetn) begin
         sum_q       <= 32'h00000000;
         count_q     <= 8'h00;
         last_time_q <= 16'h0000;
         armed_q     <= 1'b0;
         active_q    <= 1'b0;
      end else begin
         sum_q       <= sum_d;
         count_q     <= count_d;
         last_time_q <= last_time_d;
         armed_q     <= armed_d;
         active_q    <= active_d;
      end
   end

   // =====================================================================
   // interrupt flag; set wins over a clear in the same cycle so no event is lost
   always @* begin
      int_status_d = int_status;
      if (done)
         int_status_d = 1'b1;
      else if (int_clr)
         int_status_d = 1'b0;
      int_req_d = int_status_d & int_en;
   end

   always @(posedge clk) begin
      if (!resetn) begin
         int_status <= 1'b0;
         int_req    <= 1'b0;
      end else begin
         int_status <= int_status_d;
         int_req    <= int_req_d;
      end
   end

   // =====================================================================
   // readable total; the running sum clears on completion, so the finished
   // total is held here while the interrupt is pending
   always @* begin
      result_d = result_q;
      if (done)
         result_d = sum_next;
      else if (!int_status)
         result_d = sum_q;
   end

   always @(posedge clk) begin
      if (!resetn)
         result_q <= 32'h00000000;
      else
         result_q <= result_d;
   end

   // =====================================================================
   // parameter word readback
   assign page_ok = (rd_unit == UNIT_CODE) && (rd_chan == CHAN_NUM) &&
                    ((UNIT_CODE == `TAC_UNIT_FIRST) || (UNIT_CODE == `TAC_UNIT_SECOND));

   always @* begin
      if (!page_ok)
         rd_data_d = 16'h0000;
      else if (rd_word == `TAC_PW_CHAN)
         rd_data_d = {12'h000, func_sel};
      else if (rd_word == `TAC_PW_COUNT)
         rd_data_d = {max_count, count_q};
      else if (rd_word == `TAC_PW_LAST)
         rd_data_d = last_time_q;
      else if (rd_word == `TAC_PW_UPPER)
         rd_data_d = result_q[31:16];
      else if (rd_word == `TAC_PW_LOWER)
         rd_data_d = result_q[15:0];
      else
         rd_data_d = 16'h0000;
   end

   always @(posedge clk) begin
      if (!resetn) begin
         rd_data <= 16'h0000;
         rd_hit  <= 1'b0;
      end else begin
         rd_data <= rd_data_d;
         rd_hit  <= page_ok;
      end
   end

endmodule // tac_channel

// *** pkg/pta_map.vh ***
// constants for the time accumulator channel
`ifndef TAC_MAP_VH
`define TAC_MAP_VH
`define TAC_MODE_HIGH     2'h0
`define TAC_MODE_LOW      2'h1
`define TAC_MODE_PER_RISE 2'h2
`define TAC_MODE_PER_FALL 2'h3
`define TAC_HSR_NONE      2'h0
`define TAC_HSR_INIT      2'h3
`define TAC_PRI_OFF       2'h0
`define TAC_UNIT_FIRST    8'h41
`define TAC_UNIT_SECOND   8'h44
`define TAC_PW_CHAN       4'h0
`define TAC_PW_COUNT      4'h2
`define TAC_PW_LAST       4'h4
`define TAC_PW_UPPER      4'h8
`define TAC_PW_LOWER      4'hA
`define TAC_FUNC_NUM      4'hF
`define TAC_COUNT_MIN     8'h01
`endif

// *** test/pta_chk_checker.sv ***
// port checker for the accumulator channel
`timescale 1ns/10ps
`include "pta_map.vh"
module tac_chk #(
   parameter [7:0] UNIT_CODE = `TAC_UNIT_FIRST,
   parameter [3:0] CHAN_NUM  = 4'h0
) (
   input wire       clk,
   input wire       resetn,
   input wire       int_en,
   input wire       int_clr,
   input wire       int_status,
   input wire       int_req,
   input wire       rd_hit,
   input wire [3:0] func_sel,
   input wire [3:0] rd_chan,
   input wire [1:0] chan_pri,
   input wire [1:0] host_srv,
   input wire [7:0] rd_unit
);
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
a_req_gated: assert property (int_req |-> $past(int_en)) else $error("req no en");
a_req_follows: assert property (int_status && int_en && !int_clr |=> int_req) else $error("req lost");
a_status_holds: assert property (int_status && !int_clr |=> int_status) else $error("st lost");
a_status_clear: assert property ($fell(int_status) |-> $past(int_clr)) else $error("st fell");
a_run_gate: assert property ($rose(int_status) |-> $past(func_sel) == `TAC_FUNC_NUM && $past(chan_pri) != `TAC_PRI_OFF)
   else $error("int while off");
a_init_quiet: assert property (host_srv == `TAC_HSR_INIT |=> !$rose(int_status)) else $error("int in init");
a_page_hit: assert property (rd_unit == UNIT_CODE && rd_chan == CHAN_NUM |=> rd_hit) else $error("miss");
a_page_only: assert property (rd_hit |-> $past(rd_unit) == UNIT_CODE && $past(rd_chan) == CHAN_NUM)
   else $error("stray hit");
endmodule // tac_chk
bind tac_channel tac_chk #(.UNIT_CODE(UNIT_CODE), .CHAN_NUM(CHAN_NUM)) chk (
   .clk        (clk),
   .resetn     (resetn),
   .int_en     (int_en),
   .int_clr    (int_clr),
   .int_status (int_status),
   .int_req    (int_req),
   .rd_hit     (rd_hit),
   .func_sel   (func_sel),
   .rd_chan    (rd_chan),
   .chan_pri   (chan_pri),
   .host_srv   (host_srv),
   .rd_unit    (rd_unit)
);

// *** test/pta_sig_src.sv ***
// measured input source for the accumulator channel
`timescale 1ns/10ps
module tac_sig_src (
   input wire clk,
   output reg pin
);
initial pin = 1'b0;
// whole pulses only; every change lands on a falling edge so the rising-edge sampler never races it
task run(input int hi, input int lo, input int n);
   repeat (n) begin
      @(negedge clk) pin = 1'b1;
      repeat (hi) @(negedge clk);
      pin = 1'b0;
      repeat (lo - 1) @(negedge clk);
   end
endtask
endmodule // tac_sig_src

// *** test/tb_time_accumulator_channel.sv ***
// self-checking bench for the accumulator channel
`timescale 1ns/10ps
`include "pta_map.vh"
module tb_time_accumulator_channel;
reg         clk     = 1'b0;
reg         resetn  = 1'b0;
reg         int_en  = 1'b0;
reg         int_clr = 1'b0;
reg  [1:0]  mode    = 2'h0;
reg  [1:0]  srv     = 2'h0;
reg  [1:0]  pri     = 2'h0;
reg  [3:0]  fs      = 4'h0;
reg  [3:0]  word    = 4'h0;
reg  [3:0]  chan    = 4'h0;
reg  [7:0]  mc      = 8'h01;
reg  [7:0]  unit    = `TAC_UNIT_FIRST;
reg  [15:0] tbase   = 16'h0000;
reg  [15:0] sum_hi;
reg  [15:0] sum_lo;
reg  [15:0] word_val;
wire        pin;
wire        hit;
wire        st;
wire        req;
wire [15:0] rdat;
integer     fails   = 0;
integer     n_tests = 0;
tac_sig_src src (
   .clk (clk),
   .pin (pin)
);
tac_channel uut (
   .clk        (clk),
   .resetn     (resetn),
   .pin_in     (pin),
   .time_base  (tbase),
   .func_sel   (fs),
   .host_seq   (mode),
   .host_srv   (srv),
   .chan_pri   (pri),
   .int_en     (int_en),
   .int_clr    (int_clr),
   .max_count  (mc),
   .rd_unit    (unit),
   .rd_chan    (chan),
   .rd_word    (word),
   .rd_data    (rdat),
   .rd_hit     (hit),
   .int_status (st),
   .int_req    (req)
);
initial forever #2 clk = ~clk;
always @(negedge clk) tbase <= tbase + 16'h0001;
task chk(input string nm, input [31:0] seen, exp);
   n_tests = n_tests + 1;
   if (seen !== exp) begin
      fails = fails + 1;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
   end
endtask
task rd(input [3:0] w, output [15:0] d);
   @(negedge clk) word = w;
   @(negedge clk) d = rdat;
endtask
task tally_and_finish;
   $display("checks %0d mismatches %0d", n_tests, fails);
   if (fails == 0 && n_tests > 0) $display("TB: PASS");
   else $display("TB: FAIL");
   $finish;
endtask
// pulses are 5 high, 9 low: period 14
task run_case(input [1:0] m, p, input [3:0] f, input e, input [7:0] c, input [31:0] exp);
   @(negedge clk) {mode, pri, fs, int_en, mc, srv, int_clr} = {m, p, f, e, c, `TAC_HSR_INIT, 1'b1};
   @(negedge clk) {srv, int_clr} = {`TAC_HSR_NONE, 1'b0};
   repeat (3) @(negedge clk);
   chk("cleared", st, 32'h00000000);
   src.run(5, 9, c + 2);
   repeat (8) @(negedge clk);
   chk("status", st, exp != 0);
   chk("req", req, e && exp != 0);
   if (exp != 0) begin
      rd(`TAC_PW_UPPER, sum_hi);
      rd(`TAC_PW_LOWER, sum_lo);
      chk("sum", {sum_hi, sum_lo}, exp);
   end
endtask
// five pulses at a count of three: two measurements restart after the interrupt
task test_high;
   run_case(`TAC_MODE_HIGH, 2'h1, `TAC_FUNC_NUM, 1'b1, 8'h03, 32'h0000000F);
   rd(`TAC_PW_COUNT, word_val);
   chk("count word", word_val, 32'h00000302);
   @(negedge clk) srv = 2'h1;
   @(negedge clk) srv = `TAC_HSR_NONE;
   rd(`TAC_PW_COUNT, word_val);
   chk("unused service", word_val, 32'h00000302);
   rd(`TAC_PW_CHAN, word_val);
   chk("chan word", word_val, {28'h0000000, `TAC_FUNC_NUM});
   $display("test high done");
endtask
task test_low;
   run_case(`TAC_MODE_LOW, 2'h2, `TAC_FUNC_NUM, 1'b0, 8'h03, 32'h0000001B);
   $display("test low done");
endtask
task test_rise;
   run_case(`TAC_MODE_PER_RISE, 2'h3, `TAC_FUNC_NUM, 1'b1, 8'hFF, 32'h00000DF2);
   $display("test rise done");
endtask
task test_fall;
   run_case(`TAC_MODE_PER_FALL, 2'h3, `TAC_FUNC_NUM, 1'b1, 8'h01, 32'h0000000E);
   $display("test fall done");
endtask
task test_off;
   run_case(`TAC_MODE_HIGH, `TAC_PRI_OFF, `TAC_FUNC_NUM, 1'b1, 8'h01, 32'h00000000);
   $display("test off done");
endtask
task test_func;
   run_case(`TAC_MODE_HIGH, 2'h1, 4'h5, 1'b1, 8'h01, 32'h00000000);
   $display("test func done");
endtask
task test_page;
   unit = `TAC_UNIT_SECOND;
   rd(`TAC_PW_LOWER, word_val);
   chk("hit other unit", hit, 32'h00000000);
   chk("data other unit", word_val, 32'h00000000);
   {unit, chan} = {`TAC_UNIT_FIRST, 4'h1};
   rd(`TAC_PW_LOWER, word_val);
   chk("hit other chan", hit, 32'h00000000);
   chan = 4'h0;
   rd(`TAC_PW_LOWER, word_val);
   chk("hit own page", hit, 32'h00000001);
   $display("test page done");
endtask
initial begin
   repeat (8) @(negedge clk);
   resetn = 1'b1;
   test_high;
   test_low;
   test_rise;
   test_fall;
   test_off;
   test_func;
   test_page;
   tally_and_finish;
end
endmodule // tb_time_accumulator_channel
